/* File: acb_pkg.sv */
// constants, field layout and state codes for the calibration control bank
package acb_pkg;
  // register word indices; byte address is four times the index
  localparam logic [6:0] IDX_RUN   = 7'h61;  // run/hold control word
  localparam logic [6:0] IDX_CFG_A = 7'h62;  // calibration_config_a
  localparam logic [6:0] IDX_CFG_B = 7'h65;  // calibration_config_b
  localparam logic [6:0] IDX_AVG   = 7'h68;  // calibration_averaging
  localparam logic [6:0] IDX_STATE = 7'h6a;  // calibration_state, read only
  // apb byte address layout
  localparam int unsigned ADDR_W    = 12;    // paddr width
  localparam int unsigned IDX_LSB   = 2;     // word index starts here
  localparam int unsigned IDX_W     = 7;     // word index width
  localparam int unsigned DATA_W    = 32;    // apb data width
  localparam int unsigned REG_W     = 8;     // register width
  // reset values
  localparam logic [7:0] RST_RUN   = 8'h01;
  localparam logic [7:0] RST_CFG_A = 8'h01;
  localparam logic [7:0] RST_CFG_B = 8'h01;
  localparam logic [7:0] RST_AVG   = 8'h61;
  // field positions
  localparam int unsigned RUN_BIT    = 0;    // run control
  localparam int unsigned FG_SEL_BIT = 0;    // foreground_cal_select
  localparam int unsigned BG_EN_BIT  = 1;    // background_cal_enable
  localparam int unsigned FGOS_BIT   = 2;    // fg_offset_cal_enable
  localparam int unsigned BGOS_BIT   = 3;    // bg_offset_cal_enable
  localparam int unsigned OFFSET_REFERENCE_SELECT_BIT  = 2;    // offset_reference_select
  localparam int unsigned OSAVG_LSB  = 4;    // offset_average_depth low bit
  localparam int unsigned LINAVG_LSB = 0;    // linearity_average_depth low bit
  localparam int unsigned AVG_W      = 3;    // width of both depth fields
  localparam int unsigned DONE_BIT   = 0;    // foreground_complete
  localparam int unsigned STOP_BIT   = 1;    // background halt status
  localparam int unsigned CODE_LSB   = 2;    // status code low bit
  localparam int unsigned CODE_W     = 3;    // status code width
  // sequencer states, also shown as the status code
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,                       // held or waiting for run
    ST_CLEAR = 3'b001,                       // stored values being cleared
    ST_FG    = 3'b010,                       // foreground pass running
    ST_BG    = 3'b011,                       // background calibration running
    ST_HALT  = 3'b100                        // finished, background off
  } acb_state_t;
endpackage

/* File: acb_cfg_if.sv */
// settings and status carried between the register bank and the sequencer
`timescale 1ns/1ps
interface acb_cfg_if;
  logic                    run;          // calibration allowed to run
  logic                    fg_sel;       // foreground_cal_select
  logic                    bg_en;        // background_cal_enable
  logic                    fgos_en;      // fg_offset_cal_enable
  logic                    bgos_en;      // bg_offset_cal_enable
  logic                    offset_reference_select;        // offset_reference_select
  logic [2:0]              offset_average_depth;       // offset_average_depth
  logic [2:0]              lin_avg;      // linearity_average_depth
  logic                    foreground_complete;      // foreground_complete status
  logic                    stopped;      // background halt status
  logic [2:0]              code;         // status code
  modport regs (output run, fg_sel, bg_en, fgos_en, bgos_en, offset_reference_select, offset_average_depth, lin_avg,
                input foreground_complete, stopped, code);
  modport seq  (input run, fg_sel, bg_en, fgos_en, bgos_en, offset_reference_select, offset_average_depth, lin_avg,
                output foreground_complete, stopped, code);
endinterface

/* File: acb_seq.sv */
// calibration sequencer: clear, foreground pass, background run and status
`timescale 1ns/1ps
module acb_seq (
  input  wire logic   pclk,              // control clock
  input  wire logic   presetn,           // async reset, active low
  input  wire logic   ce,                // clock enable, freezes state when low
  acb_cfg_if.seq      cfg,               // settings in, status out
  input  wire logic   fg_pass_done,      // engine pulse: foreground pass finished
  input  wire logic   bg_paused,         // engine level: background paused at phase
  output logic        cal_values_clear,  // one-cycle pulse: wipe stored values
  output logic        fg_cal_run,        // foreground linearity pass active
  output logic        fg_offset_run,     // foreground offset pass active
  output logic        bg_cal_run,        // background calibration active
  output logic        bg_offset_run,     // background offset calibration active
  output logic        offset_ref_spare,  // offset target: 0 mid-code, 1 spare converter
  output logic [2:0]  offset_avg,        // offset averaging depth in use
  output logic [2:0]  lin_avg            // linearity averaging depth in use
);
  import acb_pkg::*;

  typedef struct packed {
    acb_state_t state;                   // sequencer state
    logic       fg_sel;                  // settings latched at start
    logic       bg_en;
    logic       fgos;
    logic       bgos;
    logic       offset_reference_select;
    logic [2:0] offset_average_depth;
    logic [2:0] lin_avg;
    logic       foreground_complete;                 // foreground complete or skipped
    logic       stopped;                 // background halt status
    logic       clr;                     // clear pulse
  } acb_seq_t;

  acb_seq_t seq_reg;                     // registered state
  acb_seq_t seq_next;                    // next state

  // next-state logic
  always_comb begin
    seq_next     = seq_reg;
    seq_next.clr = 1'b0;
    if (!cfg.run) begin
      // run bit low holds state and status in reset; latched settings kept
      seq_next.state   = ST_IDLE;
      seq_next.foreground_complete = 1'b0;
      seq_next.stopped = 1'b0;
    end else begin
      unique case (seq_reg.state)
        ST_IDLE: begin
          // latch settings and clear status at start
          seq_next.fg_sel  = cfg.fg_sel;
          seq_next.bg_en   = cfg.bg_en;
          seq_next.fgos    = cfg.fgos_en;
          seq_next.bgos    = cfg.bgos_en;
          seq_next.offset_reference_select   = cfg.offset_reference_select;
          seq_next.offset_average_depth  = cfg.offset_average_depth;
          seq_next.lin_avg = cfg.lin_avg;
          seq_next.foreground_complete = 1'b0;
          seq_next.stopped = 1'b0;
          seq_next.clr     = 1'b1;      // values cleared either way
          seq_next.state   = ST_CLEAR;
        end
        ST_CLEAR: begin
          if (seq_reg.fg_sel) begin
            seq_next.state = ST_FG;     // run the foreground pass
          end else begin
            // foreground bypassed, counts as complete
            seq_next.foreground_complete = 1'b1;
            seq_next.stopped = !seq_reg.bg_en;
            seq_next.state   = seq_reg.bg_en ? ST_BG : ST_HALT;
          end
        end
        ST_FG: begin
          if (fg_pass_done) begin
            seq_next.foreground_complete = 1'b1;
            seq_next.stopped = !seq_reg.bg_en;
            seq_next.state   = seq_reg.bg_en ? ST_BG : ST_HALT;
          end
        end
        ST_BG: begin
          // halt status follows pause, drops on resume
          seq_next.stopped = bg_paused;
        end
        ST_HALT: begin
          seq_next.stopped = 1'b1;
        end
        default: begin
          seq_next.state = ST_IDLE;     // illegal code recovers
        end
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seq_reg <= '{state: ST_IDLE, default: '0};
    end else if (ce) begin
      seq_reg <= seq_next;
    end
  end

  // engine controls decoded from registered state
  assign cal_values_clear = seq_reg.clr;
  assign fg_cal_run       = (seq_reg.state == ST_FG);
  assign fg_offset_run    = (seq_reg.state == ST_FG) && seq_reg.fgos;
  assign bg_cal_run       = (seq_reg.state == ST_BG);
  assign bg_offset_run    = (seq_reg.state == ST_BG) && seq_reg.bgos;
  assign offset_ref_spare = seq_reg.offset_reference_select;
  assign offset_avg       = seq_reg.offset_average_depth;
  assign lin_avg          = seq_reg.lin_avg;
  // status back to the register bank
  assign cfg.foreground_complete      = seq_reg.foreground_complete;
  assign cfg.stopped      = seq_reg.stopped;
  assign cfg.code         = seq_reg.state;
endmodule

/* File: acb_regs.sv */
// apb register bank for the converter calibration engine, with its sequencer
//
// How it works
// - foreground select set: clear values, run foreground
// - foreground select clear: clear values, skip foreground
// - background runs only if its enable set at start
// - reference clear: calibrate offset to mid-code
// - reference set: match primaries to spare converter
// - offset depth field bits 6:4, reset 6
// - linearity depth field bits 2:0, reset 1
// - halt bit high once background paused
// - halt bit drops when calibration resumes
// - background off: halt set after foreground
// - complete bit high after foreground done/skipped
// - status register read only, writes ignored
// - run bit low holds calibration in reset
//
// the bank answers each apb access one cycle after setup when ce is high in both cycles;
// read data is captured at the setup cycle into a flop so prdata
// never comes straight from the address decoder.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
module acb_regs (
  input  wire logic                         pclk,             // control clock, 200 mhz
  input  wire logic                         presetn,          // async reset, active low
  input  wire logic                         ce,               // clock enable, freezes state when low
  input  wire logic                         psel,             // apb select
  input  wire logic                         penable,          // apb access phase
  input  wire logic                         pwrite,           // apb direction, high writes
  input  wire logic [acb_pkg::ADDR_W-1:0]   paddr,            // apb byte address
  input  wire logic [acb_pkg::DATA_W-1:0]   pwdata,           // apb write data
  input  wire logic [3:0]                   pstrb,            // apb byte strobes
  output logic      [acb_pkg::DATA_W-1:0]   prdata,           // apb read data, registered
  output logic                              pready,           // apb ready
  output logic                              pslverr,          // apb error, registered
  input  wire logic                         fg_pass_done,     // engine: foreground pass done pulse
  input  wire logic                         bg_paused,        // engine: background paused level
  output logic                              cal_values_clear, // pulse: wipe stored calibration
  output logic                              fg_cal_run,       // foreground linearity pass active
  output logic                              fg_offset_run,    // foreground offset pass active
  output logic                              bg_cal_run,       // background calibration active
  output logic                              bg_offset_run,    // background offset active
  output logic                              offset_ref_spare, // offset target select
  output logic      [2:0]                   offset_avg,       // offset averaging depth
  output logic      [2:0]                   lin_avg           // linearity averaging depth
);
  import acb_pkg::*;

  // word index of a byte address
  function automatic logic [IDX_W-1:0] word_idx(input logic [ADDR_W-1:0] a);
    word_idx = a[IDX_LSB +: IDX_W];
  endfunction

  // true for any index this bank answers
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [IDX_W-1:0] i;
    i = word_idx(a);
    is_mapped = (a[IDX_LSB-1:0] == 2'b00) &&
                (a[ADDR_W-1:IDX_LSB+IDX_W] == '0) &&
                ((i == IDX_RUN) || (i == IDX_CFG_A) || (i == IDX_CFG_B) ||
                 (i == IDX_AVG) || (i == IDX_STATE));
  endfunction

  // all bank state in one record
  typedef struct packed {
    logic [REG_W-1:0]  run;              // run control word
    logic [REG_W-1:0]  cfg_a;            // calibration_config_a
    logic [REG_W-1:0]  cfg_b;            // calibration_config_b
    logic [REG_W-1:0]  avg;              // calibration_averaging
    logic [DATA_W-1:0] rdata;            // captured read data
    logic              err;              // captured error
    logic              armed;            // setup seen, answer due
  } acb_bank_t;

  acb_bank_t bank_reg;                   // registered bank
  acb_bank_t bank_next;                  // next bank value

  acb_cfg_if cfg ();                     // link to sequencer

  logic              setup_ph;           // apb setup cycle
  logic              access_ok;          // access completes this edge
  logic              wr_hit;             // write completes this edge
  logic [IDX_W-1:0]  acc_idx;            // index of current access
  logic [REG_W-1:0]  status_word;        // live status image
  logic [REG_W-1:0]  rd_word;            // read mux output

  // apb phase decode
  assign setup_ph  = psel && !penable;
  assign access_ok = psel && penable && ce && bank_reg.armed;
  assign wr_hit    = access_ok && pwrite && pstrb[0] && is_mapped(paddr);
  assign acc_idx   = word_idx(paddr);

  // status image, reserved bits zero
  always_comb begin
    status_word                          = '0;
    status_word[DONE_BIT]                = cfg.foreground_complete;
    status_word[STOP_BIT]                = cfg.stopped;
    status_word[CODE_LSB +: CODE_W]      = cfg.code;
  end

  // read mux
  always_comb begin
    unique case (acc_idx)
      IDX_RUN:   rd_word = bank_reg.run;
      IDX_CFG_A: rd_word = bank_reg.cfg_a;
      IDX_CFG_B: rd_word = bank_reg.cfg_b;
      IDX_AVG:   rd_word = bank_reg.avg;
      IDX_STATE: rd_word = status_word;
      default:   rd_word = '0;           // unmapped reads zero
    endcase
  end

  // bank next-state
  always_comb begin
    bank_next = bank_reg;
    if (setup_ph) begin
      // capture the answer at setup so it comes from a flop
      bank_next.armed = 1'b1;
      bank_next.err   = !is_mapped(paddr);
      bank_next.rdata = pwrite ? '0 : {{(DATA_W-REG_W){1'b0}}, rd_word};
    end else if (access_ok) begin
      bank_next.armed = 1'b0;
    end
    if (wr_hit) begin
      // reserved bits stored as written; software keeps defaults
      unique case (acc_idx)
        IDX_RUN:   bank_next.run   = pwdata[REG_W-1:0];
        IDX_CFG_A: bank_next.cfg_a = pwdata[REG_W-1:0];
        IDX_CFG_B: bank_next.cfg_b = pwdata[REG_W-1:0];
        IDX_AVG:   bank_next.avg   = pwdata[REG_W-1:0];
        default:   bank_next.run   = bank_reg.run;             // status write dropped
      endcase
    end
  end

  // bank register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_reg <= '{run:   RST_RUN,
                    cfg_a: RST_CFG_A,
                    cfg_b: RST_CFG_B,
                    avg:   RST_AVG,
                    rdata: '0,
                    err:   1'b0,
                    armed: 1'b0};
    end else if (ce) begin
      bank_reg <= bank_next;
    end
  end

  // apb answer
  assign pready  = access_ok;
  assign prdata  = bank_reg.rdata;
  assign pslverr = bank_reg.err;

  // settings to the sequencer; dependencies between enables are left to software
  assign cfg.run     = bank_reg.run[RUN_BIT];
  assign cfg.fg_sel  = bank_reg.cfg_a[FG_SEL_BIT];
  assign cfg.bg_en   = bank_reg.cfg_a[BG_EN_BIT];
  assign cfg.fgos_en = bank_reg.cfg_a[FGOS_BIT];
  assign cfg.bgos_en = bank_reg.cfg_a[BGOS_BIT];
  assign cfg.offset_reference_select   = bank_reg.cfg_b[OFFSET_REFERENCE_SELECT_BIT];
  assign cfg.offset_average_depth  = bank_reg.avg[OSAVG_LSB +: AVG_W];
  assign cfg.lin_avg = bank_reg.avg[LINAVG_LSB +: AVG_W];

  // sequencer
  acb_seq u_seq (
    .pclk             (pclk),
    .presetn          (presetn),
    .ce               (ce),
    .cfg              (cfg),
    .fg_pass_done     (fg_pass_done),
    .bg_paused        (bg_paused),
    .cal_values_clear (cal_values_clear),
    .fg_cal_run       (fg_cal_run),
    .fg_offset_run    (fg_offset_run),
    .bg_cal_run       (bg_cal_run),
    .bg_offset_run    (bg_offset_run),
    .offset_ref_spare (offset_ref_spare),
    .offset_avg       (offset_avg),
    .lin_avg          (lin_avg)
  );
endmodule

/* File: acb_chk_assertions.sv */
// port-level assertion checker for the calibration control bank
`timescale 1ns/1ps
module acb_chk (
  input wire logic                       pclk,             // clock
  input wire logic                       presetn,          // reset, active low
  input wire logic                       ce,               // clock enable
  input wire logic                       psel,             // apb select
  input wire logic                       penable,          // apb access
  input wire logic                       pwrite,           // apb direction
  input wire logic [acb_pkg::ADDR_W-1:0] paddr,            // apb address
  input wire logic [acb_pkg::DATA_W-1:0] pwdata,           // apb write data
  input wire logic [3:0]                 pstrb,            // apb strobes
  input wire logic [acb_pkg::DATA_W-1:0] prdata,           // apb read data
  input wire logic                       pready,           // apb ready
  input wire logic                       pslverr,          // apb error
  input wire logic                       fg_pass_done,     // foreground pass done
  input wire logic                       bg_paused,        // background paused
  input wire logic                       cal_values_clear, // wipe pulse
  input wire logic                       fg_cal_run,       // foreground active
  input wire logic                       fg_offset_run,    // fg offset active
  input wire logic                       bg_cal_run,       // background active
  input wire logic                       bg_offset_run,    // bg offset active
  input wire logic                       offset_ref_spare, // offset target
  input wire logic [2:0]                 offset_avg,       // offset depth
  input wire logic [2:0]                 lin_avg           // linearity depth
);
  import acb_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb phases as seen at the ports
  sequence s_setup; psel && !penable && ce; endsequence
  sequence s_access; psel && penable && ce; endsequence
  property p_ready_after_setup; s_setup ##1 s_access |-> pready; endproperty
  property p_ready_one; pready |=> !pready; endproperty
  property p_clear_pulse; cal_values_clear |=> !cal_values_clear; endproperty
  property p_fg_after_clear; $rose(fg_cal_run) |-> $past(cal_values_clear); endproperty
  property p_fg_leave; fg_cal_run && fg_pass_done && ce |=> !fg_cal_run; endproperty
  property p_excl; !(fg_cal_run && bg_cal_run); endproperty
  property p_bgos; bg_offset_run |-> bg_cal_run; endproperty
  property p_fgos; fg_offset_run |-> fg_cal_run; endproperty
  property p_latch; fg_cal_run || bg_cal_run |-> $stable(offset_avg) && $stable(lin_avg); endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("pready missing one cycle after setup");
  a_ready_one: assert property (p_ready_one)
    else $error("pready stood longer than one cycle");
  a_clear_pulse: assert property (p_clear_pulse)
    else $error("clear pulse longer than one cycle");
  a_fg_after_clear: assert property (p_fg_after_clear)
    else $error("foreground started without a clear first");
  a_fg_leave: assert property (p_fg_leave)
    else $error("foreground pass did not end on its done pulse");
  a_excl: assert property (p_excl)
    else $error("foreground and background active together");
  a_bgos: assert property (p_bgos)
    else $error("background offset active without background");
  a_fgos: assert property (p_fgos)
    else $error("foreground offset active without foreground");
  a_latch: assert property (p_latch)
    else $error("depth changed during a run");
endmodule

bind acb_regs acb_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .fg_pass_done(fg_pass_done), .bg_paused(bg_paused), .cal_values_clear(cal_values_clear),
  .fg_cal_run(fg_cal_run), .fg_offset_run(fg_offset_run), .bg_cal_run(bg_cal_run),
  .bg_offset_run(bg_offset_run), .offset_ref_spare(offset_ref_spare), .offset_avg(offset_avg), .lin_avg(lin_avg));

/* File: testbench.sv */
// self-checking bench for the calibration control bank
`timescale 1ns/1ps
module testbench;
  import acb_pkg::*;
  logic              pclk, presetn, ce, psel, penable, pwrite;  // clock, reset, apb
  logic [ADDR_W-1:0] paddr;                                     // apb address
  logic [DATA_W-1:0] pwdata, prdata, rd;                        // apb data, last read
  logic [3:0]        pstrb;                                     // apb strobes
  logic              pready, pslverr, er, fg_seen;              // apb answer, flags
  logic              fg_pass_done, bg_paused, cal_values_clear; // engine side
  logic              fg_cal_run, fg_offset_run, bg_cal_run, bg_offset_run, offset_ref_spare;
  logic [2:0]        offset_avg, lin_avg;                       // depths in use
  int                err_total, cmp_count, clr_cnt;             // counters, clear pulses seen

  acb_regs dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fg_pass_done(fg_pass_done), .bg_paused(bg_paused), .cal_values_clear(cal_values_clear),
    .fg_cal_run(fg_cal_run), .fg_offset_run(fg_offset_run), .bg_cal_run(bg_cal_run),
    .bg_offset_run(bg_offset_run), .offset_ref_spare(offset_ref_spare), .offset_avg(offset_avg),
    .lin_avg(lin_avg));

  // 200 mhz clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // remembers whether a foreground pass ran
  always @(posedge pclk) begin
    if (fg_cal_run === 1'b1) fg_seen <= 1'b1;
  end
  // counts clear pulses since the last restart
  always @(posedge pclk) begin
    if (cal_values_clear === 1'b1) clr_cnt <= clr_cnt + 1;
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // status word: code, halt, complete
  function automatic logic [31:0] stat(input acb_state_t c, input logic h, input logic d);
    return {27'h0, c, h, d};
  endfunction
  // one apb transfer; waits for pready with a bound
  task automatic apb(input logic wr, input logic [6:0] idx, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= {3'h0, idx, 2'h0}; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (pready !== 1'b1) begin
      err_total++;
      print_verdict();
    end
  endtask
  task automatic pulse_done();
    @(posedge pclk);
    fg_pass_done <= 1'b1;
    @(posedge pclk);
    fg_pass_done <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  task automatic t_defaults();
    apb(0, IDX_RUN, 0);   check(rd, 32'h01, "run reset");
    apb(0, IDX_CFG_A, 0); check(rd, 32'h01, "cfg_a reset");
    apb(0, IDX_CFG_B, 0); check(rd, 32'h01, "cfg_b reset");
    apb(0, IDX_AVG, 0);   check(rd, 32'h61, "avg reset");
    check(offset_avg, 3'h6, "offset depth");
    check(lin_avg, 3'h1, "linearity depth");
    check(fg_cal_run, 1'b1, "foreground runs");
    check(bg_cal_run, 1'b0, "background off");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_FG, 0, 0), "status in fg");
  endtask
  task automatic t_fg_end_readonly();
    pulse_done();
    check(fg_cal_run, 1'b0, "fg ended");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_HALT, 1, 1), "halt set");
    apb(1, IDX_STATE, 32'hff);
    check(er, 1'b0, "status write no error");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_HALT, 1, 1), "status kept");
    pstrb <= 4'he;
    apb(1, IDX_AVG, 32'h11);
    pstrb <= 4'hf;
    apb(0, IDX_AVG, 0);   check(rd, 32'h61, "write without low strobe dropped");
    apb(0, 7'h00, 0);     check(rd, 32'h0, "unmapped reads zero");
    check(er, 1'b1, "unmapped error");
  endtask
  task automatic restart(input logic [7:0] a, input logic [7:0] b, input logic [7:0] v);
    apb(1, IDX_RUN, 0); apb(1, IDX_CFG_A, a); apb(1, IDX_CFG_B, b); apb(1, IDX_AVG, v);
    check(fg_cal_run | bg_cal_run, 1'b0, "held while run low");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_IDLE, 0, 0), "status idle");
    fg_seen = 1'b0;
    clr_cnt = 0;
    apb(1, IDX_RUN, 32'h01);
    repeat (3) @(posedge pclk);
  endtask
  task automatic t_bg_skip();
    restart(8'h0a, 8'h05, 8'h35);
    check(fg_seen, 1'b0, "foreground skipped");
    check(clr_cnt, 32'd1, "one clear on skip");
    check({bg_cal_run, bg_offset_run}, 2'b11, "background runs");
    check(offset_ref_spare, 1'b1, "spare reference");
    check({offset_avg, lin_avg}, 6'o35, "new depths");
    apb(0, IDX_CFG_B, 0); check(rd, 32'h05, "cfg_b readback");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_BG, 0, 1), "bg running");
    bg_paused <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(0, IDX_STATE, 0); check(rd, stat(ST_BG, 1, 1), "bg halted");
    bg_paused <= 1'b0;
    repeat (2) @(posedge pclk);
    apb(0, IDX_STATE, 0); check(rd, stat(ST_BG, 0, 1), "bg resumed");
  endtask
  task automatic t_fg_offset();
    restart(8'h05, 8'h01, 8'h35);
    check(clr_cnt, 32'd1, "one clear before foreground");
    check({fg_cal_run, fg_offset_run}, 2'b11, "fg offset runs");
    check(offset_ref_spare, 1'b0, "mid-code reference");
    apb(1, IDX_AVG, 32'h77);
    check(offset_avg, 3'h3, "depth latched at start");
    ce <= 1'b0;
    pulse_done();
    check(fg_cal_run, 1'b1, "frozen while ce low");
    ce <= 1'b1;
    pulse_done();
    check(fg_offset_run, 1'b0, "fg offset ended");
    apb(0, IDX_STATE, 0); check(rd, stat(ST_HALT, 1, 1), "done, halt");
  endtask

  // watchdog against a hang
  initial begin
    #200us;
    err_total++;
    print_verdict();
  end
  // reset, then the scenarios
  initial begin
    err_total = 0; cmp_count = 0; fg_seen = 1'b0; clr_cnt = 0;
    presetn = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = '0; pwdata = '0; pstrb = 4'hf; fg_pass_done = 1'b0; bg_paused = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_fg_end_readonly();
    t_bg_skip();
    t_fg_offset();
    print_verdict();
  end
endmodule
